/* rtl/sbpt_pkg.sv */
// Shared constants and types of the 16-bit period timer.
// Assumes a 32-bit AXI4-Lite slave port with an 8-bit byte address.
package sbpt_pkg;

   // Register byte addresses
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h08;
   localparam logic [7:0] OFS_PERIOD_LOW = 8'h0C;
   localparam logic [7:0] OFS_PERIOD_HIGH = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;

   // Reset values and maximum count
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [7:0] BUFFER_RST = 8'h00;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // Status register fields
   localparam int STATUS_FLAG_BIT = 0;
   localparam int STATUS_RUN_BIT = 1;

   // Sample history {newest, middle, oldest} that marks a rising edge
   localparam logic [2:0] RISE_PATTERN = 3'h6;

   // Prescaler terminal counts for codes 00, 01, 10, 11
   localparam logic [2:0] DIV1_LAST = 3'h0;
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV4_LAST = 3'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic sleep_run_enable;
      logic event_reset_disable;
      logic single_shot_select;
      logic [1:0] prescale_select;
      logic no_sync_select;
      logic clock_source_select;
      logic timer_enable;
   } sbpt_ctrl_type;

   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } sbpt_phase_type;

endpackage

/* rtl/sbpt_top.sv */
// 16-bit period timer/counter with AXI4-Lite register access.
// Assumes the external count clock and event reset are synchronous to CLK;
// one CLK period is one quarter phase of the instruction cycle.
//
// Notes on behaviour
// - 16-bit count, high byte via buffer
// - Period match rolls count, sets flag
// - Control bit 0 enables timer
// - Control bit 7 keeps the unsynchronized external counter running in sleep
// - Control bit 6 disables event reset
// - Control bit 5 selects single-shot
// - Bits 4-3 prescale by 1,2,4,8
// - Bit 2 bypasses sync, external only
// - Bit 1 selects external count pin
// - Timer mode counts on first quarter
// - Sync counter: three samples, count next Q1
// - Async counter counts unsynchronized edges
// - Disable keeps count; software may preload
// - Period writes accepted while running
// - Match or FFFFh clears; single-shot stops
// - Low read/write moves buffered high byte
// - Prescaler cleared by low write, disable, reset
// - Event reset clears; bus write wins
`timescale 1ns/10ps
module sbpt_top (
   input wire logic CLK, // System clock, one quarter phase
   input wire logic RST_N, // Synchronous reset
   input wire logic S_AXI_AWVALID, // Write address valid
   output logic S_AXI_AWREADY, // Write address ready
   input wire logic [7:0] S_AXI_AWADDR, // Write byte address
   input wire logic S_AXI_WVALID, // Write data valid
   output logic S_AXI_WREADY, // Write data ready
   input wire logic [31:0] S_AXI_WDATA, // Write data
   input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes
   output logic S_AXI_BVALID, // Write response valid
   input wire logic S_AXI_BREADY, // Write response ready
   output logic [1:0] S_AXI_BRESP, // Write response
   input wire logic S_AXI_ARVALID, // Read address valid
   output logic S_AXI_ARREADY, // Read address ready
   input wire logic [7:0] S_AXI_ARADDR, // Read byte address
   output logic S_AXI_RVALID, // Read data valid
   input wire logic S_AXI_RREADY, // Read data ready
   output logic [31:0] S_AXI_RDATA, // Read data
   output logic [1:0] S_AXI_RRESP, // Read response
   input wire logic EXTERNAL_COUNT_CLOCK, // External count source
   input wire logic EVENT_RESET, // Special-event reset request
   input wire logic SLEEP, // Device sleep state
   output logic IRQ // Period-match interrupt request
);

   sbpt_pkg::sbpt_ctrl_type ctrl_r;
   sbpt_pkg::sbpt_phase_type phase_r;
   logic [15:0] count_r;
   logic [7:0] buffer_r;
   logic [15:0] period_r;
   logic flag_r;
   logic [2:0] pre_r;
   logic [2:0] pre_last;
   logic [2:0] samp_r;
   logic pend_r;
   logic ext_d_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_go;
   logic rd_go;
   logic wr_byte;
   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic wr_plow;
   logic wr_phigh;
   logic wr_stat;
   logic rd_low;
   logic q1;
   logic sample_now;
   logic sync_tick;
   logic async_tick;
   logic tick;
   logic run;
   logic count_en;
   logic match;
   logic evt;
   logic [31:0] rd_mux;
   logic rd_hit;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   // Address and data are taken together; one write and one read in flight
   assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_r;
   assign S_AXI_AWREADY = wr_go;
   assign S_AXI_WREADY = wr_go;
   assign rd_go = S_AXI_ARVALID & ~rvalid_r;
   assign S_AXI_ARREADY = rd_go;
   assign wr_byte = wr_go & S_AXI_WSTRB[0];

   assign wr_ctrl = wr_byte & (S_AXI_AWADDR == sbpt_pkg::OFS_CONTROL);
   assign wr_low = wr_byte & (S_AXI_AWADDR == sbpt_pkg::OFS_COUNT_LOW);
   assign wr_high = wr_byte & (S_AXI_AWADDR == sbpt_pkg::OFS_COUNT_HIGH);
   assign wr_plow = wr_byte & (S_AXI_AWADDR == sbpt_pkg::OFS_PERIOD_LOW);
   assign wr_phigh = wr_byte & (S_AXI_AWADDR == sbpt_pkg::OFS_PERIOD_HIGH);
   assign wr_stat = wr_byte & (S_AXI_AWADDR == sbpt_pkg::OFS_STATUS);
   assign rd_low = rd_go & (S_AXI_ARADDR == sbpt_pkg::OFS_COUNT_LOW);

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (S_AXI_ARADDR)
         sbpt_pkg::OFS_CONTROL: rd_mux[7:0] = ctrl_r;
         sbpt_pkg::OFS_COUNT_LOW: rd_mux[7:0] = count_r[7:0];
         sbpt_pkg::OFS_COUNT_HIGH: rd_mux[7:0] = buffer_r;
         sbpt_pkg::OFS_PERIOD_LOW: rd_mux[7:0] = period_r[7:0];
         sbpt_pkg::OFS_PERIOD_HIGH: rd_mux[7:0] = period_r[15:8];
         sbpt_pkg::OFS_STATUS: begin
            rd_mux[sbpt_pkg::STATUS_FLAG_BIT] = flag_r;
            rd_mux[sbpt_pkg::STATUS_RUN_BIT] = run;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         bvalid_r <= 1'b0;
         bresp_r <= sbpt_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= (wr_ctrl | wr_low | wr_high | wr_plow | wr_phigh | wr_stat |
                     ~S_AXI_WSTRB[0]) ? sbpt_pkg::RESP_OKAY : sbpt_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= sbpt_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? sbpt_pkg::RESP_OKAY : sbpt_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;

   ////////////////////////////////////////////////////////////////////////
   // Quarter phases and count sources

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         phase_r <= sbpt_pkg::PH_Q1;
      end else begin
         case (phase_r)
            sbpt_pkg::PH_Q1: phase_r <= sbpt_pkg::PH_Q2;
            sbpt_pkg::PH_Q2: phase_r <= sbpt_pkg::PH_Q3;
            sbpt_pkg::PH_Q3: phase_r <= sbpt_pkg::PH_Q4;
            sbpt_pkg::PH_Q4: phase_r <= sbpt_pkg::PH_Q1;
            default: phase_r <= sbpt_pkg::PH_Q1;
         endcase
      end
   end

   assign q1 = (phase_r == sbpt_pkg::PH_Q1);
   assign sample_now = (phase_r == sbpt_pkg::PH_Q2) | (phase_r == sbpt_pkg::PH_Q4);

   // Pin sampled on Q2 and Q4; edges narrower than half a cycle are missed
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         samp_r <= 3'h0;
         pend_r <= 1'b0;
      end else begin
         if (sample_now) begin
            samp_r <= {EXTERNAL_COUNT_CLOCK, samp_r[2:1]};
         end
         if (sample_now && {EXTERNAL_COUNT_CLOCK, samp_r[2:1]} == sbpt_pkg::RISE_PATTERN) begin
            pend_r <= 1'b1;
         end else if (q1) begin
            pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ext_d_r <= 1'b0;
      end else begin
         ext_d_r <= EXTERNAL_COUNT_CLOCK;
      end
   end

   assign sync_tick = q1 & pend_r;
   assign async_tick = EXTERNAL_COUNT_CLOCK & ~ext_d_r;
   // No-sync bit only matters with the external source
   assign tick = ctrl_r.clock_source_select ?
                 (ctrl_r.no_sync_select ? async_tick : sync_tick) : q1;

   // Sleep stops all but the unsynchronized external counter with sleep-run enabled
   assign run = ctrl_r.timer_enable & (~SLEEP | (ctrl_r.sleep_run_enable &
                ctrl_r.clock_source_select & ctrl_r.no_sync_select));

   ////////////////////////////////////////////////////////////////////////
   // Prescaler

   always_comb begin
      case (ctrl_r.prescale_select)
         2'h0: pre_last = sbpt_pkg::DIV1_LAST;
         2'h1: pre_last = sbpt_pkg::DIV2_LAST;
         2'h2: pre_last = sbpt_pkg::DIV4_LAST;
         2'h3: pre_last = sbpt_pkg::DIV8_LAST;
         default: pre_last = sbpt_pkg::DIV1_LAST;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N || !ctrl_r.timer_enable || wr_low) begin
         pre_r <= 3'h0;
      end else if (run && tick) begin
         pre_r <= (pre_r >= pre_last) ? 3'h0 : pre_r + 3'h1;
      end
   end

   assign count_en = run & tick & (pre_r >= pre_last);

   ////////////////////////////////////////////////////////////////////////
   // Count, buffer, period, control, flag

   assign match = (count_r == period_r) | (count_r == sbpt_pkg::COUNT_MAX);
   assign evt = EVENT_RESET & ~ctrl_r.event_reset_disable;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         count_r <= sbpt_pkg::COUNT_RST;
      end else if (wr_low) begin
         count_r <= {buffer_r, S_AXI_WDATA[7:0]};
      end else if (evt) begin
         count_r <= sbpt_pkg::COUNT_RST;
      end else if (count_en) begin
         count_r <= match ? sbpt_pkg::COUNT_RST : count_r + 16'h0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         buffer_r <= sbpt_pkg::BUFFER_RST;
      end else if (wr_high) begin
         buffer_r <= S_AXI_WDATA[7:0];
      end else if (rd_low) begin
         buffer_r <= count_r[15:8];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         period_r <= sbpt_pkg::PERIOD_RST;
      end else begin
         if (wr_plow) begin
            period_r[7:0] <= S_AXI_WDATA[7:0];
         end
         if (wr_phigh) begin
            period_r[15:8] <= S_AXI_WDATA[7:0];
         end
      end
   end

   // A software write to control wins over the hardware enable changes
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_r <= sbpt_pkg::CONTROL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= S_AXI_WDATA[7:0];
      end else if (count_en && match && ctrl_r.single_shot_select) begin
         ctrl_r.timer_enable <= 1'b0;
      end else if (evt && ctrl_r.single_shot_select && !ctrl_r.timer_enable) begin
         ctrl_r.timer_enable <= 1'b1;
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         flag_r <= 1'b0;
      end else if (count_en && match) begin
         flag_r <= 1'b1;
      end else if (wr_stat && S_AXI_WDATA[sbpt_pkg::STATUS_FLAG_BIT]) begin
         flag_r <= 1'b0;
      end
   end

   assign IRQ = flag_r;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_wrap;
      count_en && match && !wr_low && !evt;
   endsequence

   AST_WRAP: assert property (s_wrap |=> count_r == 16'h0000 && flag_r)
      else $error("Period match did not clear count and set flag");
   AST_INC: assert property (count_en && !match && !wr_low && !evt
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("Count did not advance by one");
   AST_HOLD: assert property (!ctrl_r.timer_enable && !wr_low && !evt
      |=> count_r == $past(count_r))
      else $error("Disabled timer changed its count");
   AST_SHOT: assert property (s_wrap ##0 ctrl_r.single_shot_select && !wr_ctrl
      |=> !ctrl_r.timer_enable)
      else $error("Single-shot match left timer enabled");
   AST_PRE_CLR: assert property (!ctrl_r.timer_enable |=> pre_r == 3'h0)
      else $error("Prescaler not cleared while disabled");
   AST_EVT: assert property (evt && !wr_low |=> count_r == 16'h0000)
      else $error("Event reset did not clear count");
   AST_WR_WINS: assert property (wr_low && evt
      |=> count_r == {$past(buffer_r), $past(S_AXI_WDATA[7:0])})
      else $error("Event reset overrode bus write");
   AST_RD_BUF: assert property (rd_low && !wr_high |=> buffer_r == $past(count_r[15:8]))
      else $error("Low-byte read did not capture high byte");
   AST_FLAG: assert property (flag_r && !(wr_stat && S_AXI_WDATA[0]) |=> flag_r && IRQ)
      else $error("Flag dropped without software clear");
   AST_SYNC_Q1: assert property (pend_r |-> ##[0:3] (q1 && sync_tick))
      else $error("Detected edge not counted on next Q1");
   // Internal ticks are four cycles apart, so the step before the count is four back
   AST_DIV8: assert property (ctrl_r.prescale_select == 2'h3 && count_en
      && !ctrl_r.clock_source_select |-> pre_r == 3'h7 && $past(pre_r, 4) == 3'h6)
      else $error("Divide-by-8 counted at the wrong prescale step");

endmodule

/* sim/sbpt_top_test.sv */
// Self-checking bench for the 16-bit period timer.
// Drives the AXI4-Lite port and the count pins directly; no partner model.
`timescale 1ns/10ps
module sbpt_top_test;
   localparam logic [7:0] A_CTL = sbpt_pkg::OFS_CONTROL;
   localparam logic [7:0] A_CNTL = sbpt_pkg::OFS_COUNT_LOW;
   localparam logic [7:0] A_CNTH = sbpt_pkg::OFS_COUNT_HIGH;
   localparam logic [7:0] A_PRL = sbpt_pkg::OFS_PERIOD_LOW;
   localparam logic [7:0] A_PRH = sbpt_pkg::OFS_PERIOD_HIGH;
   localparam logic [7:0] A_STS = sbpt_pkg::OFS_STATUS;
   logic clk, rst_n, awv, wv, bready, arv, rready, ext, ev, slp;
   logic awr, wrdy, bv, arr, rv, irq;
   logic [7:0] awa, ara, d;
   logic [31:0] wd, rdat;
   logic [3:0] ws;
   logic [1:0] br, rr, r, wresp;
   int failures, n_checks, cyc;

   sbpt_top DUT (.CLK(clk), .RST_N(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_BRESP(br),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rready), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
      .EXTERNAL_COUNT_CLOCK(ext), .EVENT_RESET(ev), .SLEEP(slp), .IRQ(irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Both channels offered together; response ready held high throughout
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      awv <= 1'b1;
      wv <= 1'b1;
      awa <= a;
      wd <= {24'h000000, v};
      do @(posedge clk); while (!(awr && wrdy));
      awv <= 1'b0;
      wv <= 1'b0;
      do @(posedge clk); while (!bv);
      wresp = br;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] e);
      arv <= 1'b1;
      ara <= a;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      v = rdat[7:0];
      e = rr;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      logic [1:0] e;
      rd(a, v, e);
      chk(nm, v, exp);
   endtask

   // Buffer first, so the low write moves the whole word
   task automatic load(input logic [15:0] c);
      wr(A_CNTH, c[15:8]);
      wr(A_CNTL, c[7:0]);
   endtask

   // High and low each w cycles; w of 8 keeps both levels over half a cycle
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         ext <= 1'b1;
         repeat (w) @(posedge clk);
         ext <= 1'b0;
         repeat (w) @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] adr [6];
      logic [7:0] exp [6];
      adr = '{A_CTL, A_CNTL, A_CNTH, A_PRL, A_PRH, A_STS};
      exp = '{8'h00, 8'h00, 8'h00, sbpt_pkg::PERIOD_RST[7:0], sbpt_pkg::PERIOD_RST[15:8], 8'h00};
      for (int i = 0; i < 6; i++) begin
         rchk("reset value", adr[i], exp[i]);
      end
      chk("irq at reset", irq, 1'b0);
      rd(8'h18, d, r);
      chk("unmapped read resp", r, sbpt_pkg::RESP_SLVERR);
      chk("unmapped read data", d, 8'h00);
      wr(8'h18, 8'hFF);
      chk("unmapped write resp", wresp, sbpt_pkg::RESP_SLVERR);
      $display("test reset done");
   endtask

   task automatic t_buffer;
      load(16'h1234);
      wr(A_CNTH, 8'h55);
      rchk("low after buffer write", A_CNTL, 8'h34);
      rchk("high via buffer", A_CNTH, 8'h12);
      wr(A_CTL, 8'h01);
      wr(A_CTL, 8'h00);
      load(16'h00AA);
      repeat (40) @(posedge clk);
      rchk("disabled count held", A_CNTL, 8'hAA);
      $display("test buffer done");
   endtask

   task automatic t_prescale;
      for (int ps = 0; ps < 4; ps++) begin
         load(16'h0000);
         wr(A_CTL, {3'b000, ps[1:0], 3'b001});
         repeat (128) @(posedge clk);
         wr(A_CTL, 8'h00);
         rd(A_CNTL, d, r);
         chk("prescaled count", (d >= (32 >> ps) - 1) && (d <= (33 >> ps) + 1), 1'b1);
      end
      $display("test prescale done");
   endtask

   task automatic t_period;
      load(16'h0000);
      wr(A_PRH, 8'h00);
      wr(A_CTL, 8'h01);
      wr(A_PRL, 8'h03);
      repeat (40) @(posedge clk);
      chk("match flag", irq, 1'b1);
      rchk("continuous stays on", A_CTL, 8'h01);
      rd(A_CNTL, d, r);
      chk("count within period", d <= 8'h03, 1'b1);
      wr(A_CTL, 8'h00);
      repeat (20) @(posedge clk);
      chk("flag sticky", irq, 1'b1);
      wr(A_STS, 8'h01);
      @(posedge clk);
      chk("flag cleared", irq, 1'b0);
      load(16'h0000);
      wr(A_CTL, 8'h21);
      repeat (40) @(posedge clk);
      rchk("single shot stops", A_CTL, 8'h20);
      rchk("single shot count", A_CNTL, 8'h00);
      chk("single shot flag", irq, 1'b1);
      wr(A_STS, 8'h01);
      // Wide period again so later counts never wrap
      wr(A_PRL, 8'hFF);
      $display("test period done");
   endtask

   task automatic t_event;
      wr(A_CTL, 8'h00);
      load(16'h1234);
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
      @(posedge clk);
      rchk("event clears low", A_CNTL, 8'h00);
      rchk("event clears high", A_CNTH, 8'h00);
      wr(A_CTL, 8'h40);
      load(16'h1234);
      ev <= 1'b1;
      @(posedge clk);
      ev <= 1'b0;
      @(posedge clk);
      rchk("event ignored", A_CNTL, 8'h34);
      wr(A_CTL, 8'h00);
      $display("test event done");
   endtask

   task automatic t_ext;
      load(16'h0000);
      wr(A_CTL, 8'h03);
      pulses(5, 8);
      repeat (8) @(posedge clk);
      wr(A_CTL, 8'h00);
      rchk("sync counter", A_CNTL, 8'h05);
      load(16'h0000);
      wr(A_CTL, 8'h07);
      pulses(5, 2);
      wr(A_CTL, 8'h00);
      rchk("async counter", A_CNTL, 8'h05);
      load(16'h0000);
      wr(A_CTL, 8'h05);
      repeat (40) @(posedge clk);
      wr(A_CTL, 8'h00);
      rd(A_CNTL, d, r);
      chk("internal ignores sync bit", d >= 8'h09, 1'b1);
      $display("test external done");
   endtask

   task automatic t_sleep;
      slp <= 1'b1;
      load(16'h0000);
      wr(A_CTL, 8'h01);
      repeat (40) @(posedge clk);
      rchk("internal stops in sleep", A_CNTL, 8'h00);
      wr(A_CTL, 8'h87);
      pulses(3, 2);
      rchk("sleep run counts", A_CNTL, 8'h03);
      wr(A_CTL, 8'h83);
      pulses(3, 8);
      rchk("synced stops in sleep", A_CNTL, 8'h03);
      wr(A_CTL, 8'h00);
      slp <= 1'b0;
      $display("test sleep done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Whole run needs about 1100 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         conclude;
      end
   end

   initial begin
      {rst_n, awv, wv, arv, ext, ev, slp} = '0;
      {bready, rready, ws} = {2'b11, 4'hF};
      {awa, ara, wd} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_buffer;
      t_prescale;
      t_period;
      t_event;
      t_ext;
      t_sleep;
      conclude;
   end
endmodule
